// [cbd_branch_decode.sv]
// Conditional branch decode and execute unit
`timescale 1ns/1ps

// Overview of operation
// - Upper byte 0xe6 is branch on negative; taken when negative flag is one.
// - Upper byte 0xe3 decodes as branch on carry clear.
// - Carry clear branch taken only when carry is zero, else falls through.
// - Upper byte 0xe7 decodes as branch on negative clear.
// - Negative clear branch taken only when negative flag is zero.
// - Upper byte 0xe5 decodes as branch on overflow clear.
// - Overflow clear branch taken only when overflow flag is zero.
// - Upper byte 0xe1 is branch on zero clear; taken when zero flag is zero.
// - Offset is signed two's complement, minus 128 to plus 127.
// - Taken branch doubles the offset into a byte displacement.
// - Target is incremented PC plus doubled offset.
// - One word; one cycle not taken, two cycles taken.
// - Taken branch spends second cycle as bubble, discarding fetched word.
// - Phases decode, read, process, write PC; fourth idle when not taken.
module cbd_branch_decode
  import cbd_pkg::*;
#(
  parameter int PcWidth = PC_WIDTH
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instrValid,
  input wire logic [OPCODE_WIDTH-1:0] instrWord,
  input wire logic [PcWidth-1:0] pcInc,
  input wire logic flagNegative,
  input wire logic flagCarry,
  input wire logic flagOverflow,
  input wire logic flagZero,
  output logic isBranch,
  output logic pcWriteEn,
  output logic [PcWidth-1:0] pcWriteValue,
  output logic flushFetch,
  output logic bubble,
  output logic busy,
  output logic instrDone,
  output logic flagWriteEn,
  output logic [1:0] phase
);
  logic [1:0] phase_q;
  cbd_state_e state_q;
  cbd_kind_e kind_q;
  logic [OFFSET_WIDTH-1:0] offset_q;
  logic taken_q;
  logic [PcWidth-1:0] target;
  logic [PcWidth-1:0] target_q;
  cbd_kind_e kindDec;
  logic condMet;
  logic isBranch_q;
  logic pcWriteEn_q;
  logic [PcWidth-1:0] pcWriteValue_q;
  logic flushFetch_q;
  logic bubble_q;
  logic instrDone_q;
  logic flagWriteEn_q;

  // Opcode recognition on the upper byte
  always_comb
  begin
    case (instrWord[OP_HI_MSB:OP_HI_LSB])
      OP_HI_BRANCH_ON_NEGATIVE: kindDec = CBD_NEG;
      OP_HI_BRANCH_ON_CARRY_CLEAR: kindDec = CBD_CARRY_CLR;
      OP_HI_BRANCH_ON_NEGATIVE_CLEAR: kindDec = CBD_NEG_CLR;
      OP_HI_BRANCH_ON_OVERFLOW_CLEAR: kindDec = CBD_OVF_CLR;
      OP_HI_BRANCH_ON_ZERO_CLEAR: kindDec = CBD_ZERO_CLR;
      default: kindDec = CBD_NONE;
    endcase
  end

  // Flag test for the latched branch kind
  always_comb
  begin
    case (kind_q)
      CBD_NEG: condMet = flagNegative;
      CBD_CARRY_CLR: condMet = ~flagCarry;
      CBD_NEG_CLR: condMet = ~flagNegative;
      CBD_OVF_CLR: condMet = ~flagOverflow;
      CBD_ZERO_CLR: condMet = ~flagZero;
      default: condMet = 1'b0;
    endcase
  end

  // Target adder
  cbd_target_calc #(
    .PcWidth(PcWidth)
  ) u_target (
    .pcInc(pcInc),
    .offset(offset_q),
    .target(target)
  );

  // Phase counter, free running across four phases per cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      phase_q <= PHASE_DECODE;
    else
      phase_q <= phase_q + 2'h1;
  end

  // Decode and latch literal together in the first phase
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      kind_q <= CBD_NONE;
      offset_q <= '0;
    end
    else if (state_q == CBD_ST_EXEC && phase_q == PHASE_DECODE)
    begin
      kind_q <= instrValid ? kindDec : CBD_NONE;
      offset_q <= instrWord[OFFSET_MSB:0];
    end
  end

  // Process phase evaluates condition and captures target
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      taken_q <= 1'b0;
      target_q <= '0;
    end
    else if (state_q == CBD_ST_EXEC && phase_q == PHASE_PROCESS)
    begin
      taken_q <= condMet;
      target_q <= target;
    end
  end

  // Sequencer: taken branch adds one bubble cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_q <= CBD_ST_EXEC;
    else if (phase_q == PHASE_WRITE)
    begin
      case (state_q)
        CBD_ST_EXEC:
          if (kind_q != CBD_NONE && taken_q)
            state_q <= CBD_ST_BUBBLE;
        CBD_ST_BUBBLE: state_q <= CBD_ST_EXEC;
        default: state_q <= CBD_ST_EXEC;
      endcase
    end
  end

  // Output strobes, registered
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      isBranch_q <= 1'b0;
      pcWriteEn_q <= 1'b0;
      pcWriteValue_q <= '0;
      flushFetch_q <= 1'b0;
      bubble_q <= 1'b0;
      instrDone_q <= 1'b0;
    end
    else
    begin
      isBranch_q <= state_q == CBD_ST_EXEC && phase_q != PHASE_DECODE && kind_q != CBD_NONE;
      // PC written only in fourth phase of a taken branch
      pcWriteEn_q <= state_q == CBD_ST_EXEC && phase_q == PHASE_WRITE
        && kind_q != CBD_NONE && taken_q;
      flushFetch_q <= state_q == CBD_ST_EXEC && phase_q == PHASE_WRITE
        && kind_q != CBD_NONE && taken_q;
      if (state_q == CBD_ST_EXEC && phase_q == PHASE_WRITE)
        pcWriteValue_q <= target_q;
      bubble_q <= (state_q == CBD_ST_BUBBLE);
      // Branch finishes at end of cycle one, or end of bubble
      instrDone_q <= phase_q == PHASE_WRITE && kind_q != CBD_NONE
        && ((state_q == CBD_ST_EXEC && !taken_q) || state_q == CBD_ST_BUBBLE);
    end
  end

  assign isBranch = isBranch_q;
  assign pcWriteEn = pcWriteEn_q;
  assign pcWriteValue = pcWriteValue_q;
  assign flushFetch = flushFetch_q;
  assign bubble = bubble_q;
  assign busy = bubble_q;
  assign instrDone = instrDone_q;
  // Flag write strobe held low from a flop so the port is registered
  always_ff @(posedge clk)
  begin
    flagWriteEn_q <= 1'b0;
  end

  assign flagWriteEn = flagWriteEn_q;
  assign phase = phase_q;
endmodule // cbd_branch_decode

// [cbd_pkg.sv]
// Package of constants for the conditional branch decoder
package cbd_pkg;
  localparam int PC_WIDTH = 21;
  localparam int OPCODE_WIDTH = 16;
  localparam logic [7:0] OP_HI_BRANCH_ON_NEGATIVE = 8'he6;
  localparam logic [7:0] OP_HI_BRANCH_ON_CARRY_CLEAR = 8'he3;
  localparam logic [7:0] OP_HI_BRANCH_ON_NEGATIVE_CLEAR = 8'he7;
  localparam logic [7:0] OP_HI_BRANCH_ON_OVERFLOW_CLEAR = 8'he5;
  localparam logic [7:0] OP_HI_BRANCH_ON_ZERO_CLEAR = 8'he1;
  localparam int OP_HI_MSB = 15;
  localparam int OP_HI_LSB = 8;
  localparam int OFFSET_MSB = 7;
  localparam int OFFSET_WIDTH = 8;
  localparam int PHASE_COUNT = 4;
  localparam logic [1:0] PHASE_DECODE = 2'h0;
  localparam logic [1:0] PHASE_READ = 2'h1;
  localparam logic [1:0] PHASE_PROCESS = 2'h2;
  localparam logic [1:0] PHASE_WRITE = 2'h3;
  typedef enum logic [2:0] {
    CBD_NONE,
    CBD_NEG,
    CBD_CARRY_CLR,
    CBD_NEG_CLR,
    CBD_OVF_CLR,
    CBD_ZERO_CLR
  } cbd_kind_e;
  typedef enum logic [1:0] {
    CBD_ST_EXEC,
    CBD_ST_BUBBLE
  } cbd_state_e;
endpackage

// [cbd_target_calc.sv]
// Branch target adder for the conditional branch decoder
`timescale 1ns/1ps
module cbd_target_calc
  import cbd_pkg::*;
#(
  parameter int PcWidth = PC_WIDTH
)(
  input wire logic [PcWidth-1:0] pcInc,
  input wire logic [OFFSET_WIDTH-1:0] offset,
  output logic [PcWidth-1:0] target
);
  logic [PcWidth-1:0] disp;

  // Sign extend and double the offset, then add with wrap
  always_comb
  begin
    disp = {{(PcWidth-OFFSET_WIDTH){offset[OFFSET_MSB]}}, offset};
    disp = disp << 1;
    target = pcInc + disp;
  end
endmodule // cbd_target_calc

// [cbd_assertions.sv]
// Assertions for the conditional branch decoder
`timescale 1ns/1ps
module cbd_assertions
  import cbd_pkg::*;
#(
  parameter int PcWidth = PC_WIDTH
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instrValid,
  input wire logic [OPCODE_WIDTH-1:0] instrWord,
  input wire logic [PcWidth-1:0] pcInc,
  input wire logic flagNegative,
  input wire logic flagCarry,
  input wire logic flagOverflow,
  input wire logic flagZero,
  input wire logic isBranch,
  input wire logic pcWriteEn,
  input wire logic [PcWidth-1:0] pcWriteValue,
  input wire logic flushFetch,
  input wire logic bubble,
  input wire logic busy,
  input wire logic instrDone,
  input wire logic flagWriteEn,
  input wire logic [1:0] phase
);
  logic [7:0] op;
  logic hit;
  logic isOp;
  logic take;
  logic [7:0] offQ;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Decode of the word sampled at phase zero
  assign op = instrWord[15:8];
  // Phase zero of a bubble cycle is the one flagged by the write strobe
  assign hit = instrValid && phase == 2'h0 && !pcWriteEn;
  assign isOp = hit && op inside {8'he6, 8'he3, 8'he7, 8'he5, 8'he1};
  assign take = hit && (op == 8'he6 && flagNegative || op == 8'he3 && !flagCarry
    || op == 8'he7 && !flagNegative || op == 8'he5 && !flagOverflow
    || op == 8'he1 && !flagZero);
  // Offset of the instruction in flight
  always_ff @(posedge clk)
    if (hit) offQ <= instrWord[7:0];
  a_flags_kept: assert property (!flagWriteEn) else $error("flag write seen");
  a_flush_pair: assert property (pcWriteEn == flushFetch) else $error("flush unpaired");
  a_busy_level: assert property (busy == bubble) else $error("busy differs");
  a_taken_write: assert property (take |-> ##4 pcWriteEn && !instrDone ##4 instrDone)
    else $error("taken timing wrong");
  a_skip_done: assert property (isOp && !take |-> ##4 instrDone && !pcWriteEn ##1 !bubble)
    else $error("not taken timing wrong");
  a_other_idle: assert property (hit && !isOp |-> ##4 !instrDone && !pcWriteEn)
    else $error("non branch acted");
  a_target_sum: assert property (take ##2 1 |-> ##2 pcWriteValue ==
    $past(pcInc, 2) + {{(PcWidth-9){offQ[7]}}, offQ, 1'b0}) else $error("target wrong");
  a_bubble_len: assert property ($rose(bubble) |-> bubble[*4] ##1 !bubble)
    else $error("bubble length wrong");
  a_phase_wrap: assert property (phase == 2'h3 |=> phase == 2'h0) else $error("phase wrap");
  a_branch_flag: assert property (isOp |-> ##2 isBranch[*3] ##1 !isBranch)
    else $error("branch flag wrong");
  c_taken: cover property (take);
  c_skip: cover property (isOp && !take);
  c_bubble: cover property ($rose(bubble));
endmodule // cbd_assertions

bind cbd_branch_decode cbd_assertions #(.PcWidth(PcWidth)) u_chk (.*);

// [tb_top.sv]
// Self-checking bench for the conditional branch decoder
`timescale 1ns/1ps
module tb_top;
  import cbd_pkg::*;
  logic clk, sys_rst, instrValid, flagNegative, flagCarry, flagOverflow, flagZero;
  logic isBranch, pcWriteEn, flushFetch, bubble, busy, instrDone, flagWriteEn;
  logic [15:0] instrWord;
  logic [20:0] pcInc, pcWriteValue;
  logic [1:0] phase;
  int nErrors = 0;
  int nTests = 0;
  cbd_branch_decode u_dut (.*);
  // Free running clock
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic reportAndStop();
    if (nErrors == 0 && nTests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Issue one word in a free slot, then watch the result
  task automatic exec(input [7:0] op, off, input [20:0] pc, input [3:0] f, input tk, dn);
    int i;
    logic w, d;
    logic [20:0] v;
    int nb, nf, ns;
    nb = 0;
    nf = 0;
    ns = 0;
    w = 0;
    d = 0;
    v = 0;
    i = 0;
    @(negedge clk);
    while (!(phase == 2'h3 && busy === 1'b0) && i < 40)
    begin
      @(negedge clk);
      i++;
    end
    @(posedge clk);
    instrValid <= 1;
    instrWord <= {op, off};
    pcInc <= pc;
    {flagNegative, flagCarry, flagOverflow, flagZero} <= f;
    @(posedge clk);
    instrValid <= 0;
    repeat (10)
    begin
      @(negedge clk);
      if (pcWriteEn === 1'b1) {w, v} = {1'b1, pcWriteValue};
      if (instrDone === 1'b1) d = 1;
      if (bubble === 1'b1) nb++;
      if (flushFetch === 1'b1) nf++;
      if (isBranch === 1'b1) ns++;
      if (flagWriteEn !== 1'b0) i = 99;
    end
    nTests++;
    if (i >= 40 || w !== tk || d !== dn || (tk && v !== pc + {{12{off[7]}}, off, 1'b0})
      || nb != (tk ? 4 : 0) || nf != tk || ns != (dn ? 3 : 0))
    begin
      nErrors++;
      $display("CHECK FAILED %0t op %h", $time, op);
      if (i >= 40) reportAndStop();
    end
  endtask
  // Every kind taken and skipped, other flags opposite
  task automatic checkKinds();
    logic [7:0] ops [5] = '{8'he6, 8'he3, 8'he7, 8'he5, 8'he1};
    logic [3:0] ft [5] = '{4'h8, 4'hb, 4'h7, 4'hd, 4'he};
    for (int k = 0; k < 5; k++)
    begin
      exec(ops[k], 8'h10, 21'h100, ft[k], 1, 1);
      exec(ops[k], 8'h10, 21'h100, ~ft[k], 0, 1);
    end
  endtask
  // Offset limits and wrap of the target
  task automatic checkOffsets();
    exec(8'he1, 8'h80, 21'h000100, 4'h0, 1, 1);
    exec(8'he1, 8'h7f, 21'h1ffff0, 4'h0, 1, 1);
    exec(8'he7, 8'hff, 21'h000000, 4'h0, 1, 1);
  endtask
  // Words outside the branch set
  task automatic checkOthers();
    exec(8'he2, 8'h04, 21'h200, 4'h0, 0, 0);
    exec(8'hd0, 8'h04, 21'h200, 4'h0, 0, 0);
  endtask
  // Reset in the middle of a branch clears every output
  task automatic checkReset();
    @(posedge clk);
    instrValid <= 1;
    instrWord <= 16'he105;
    flagZero <= 0;
    repeat (6) @(posedge clk);
    instrValid <= 0;
    sys_rst <= 1;
    @(posedge clk);
    @(negedge clk);
    nTests++;
    if ({isBranch, pcWriteEn, flushFetch, bubble, busy, instrDone, flagWriteEn, phase,
      pcWriteValue} !== '0)
    begin
      nErrors++;
      $display("CHECK FAILED %0t reset state", $time);
    end
    @(posedge clk);
    sys_rst <= 0;
    exec(8'he1, 8'h02, 21'h040, 4'h0, 1, 1);
  endtask
  // Reset then scenarios
  initial
  begin
    {sys_rst, instrValid, flagNegative, flagCarry, flagOverflow, flagZero} = 6'h20;
    instrWord = 16'h0000;
    pcInc = 21'h000000;
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    checkKinds();
    checkOffsets();
    checkOthers();
    checkReset();
    reportAndStop();
  end
endmodule // tb_top
